// [hdl/srd_ctx_decode.sv]
// Root and context entry walker with APB register access
// Operation
// - Table mode 01b makes root entries scalable-mode root entries.
// - Root bits 127:76 give the 4KB aligned upper context table base.
// - Upper pointer bits above host address width are treated as zero.
// - Bit 64 marks upper half valid; when clear bits 127:65 ignored.
// - Root bits 63:12 give the 4KB aligned lower context table base.
// - Lower pointer bits 63 down to host address width treated as zero.
// - Bit 0 marks lower half valid; when clear bits 63:1 ignored.
// - Context entries serve only requests without a process space id.
// - Domain tag comes from context entry bits 87:72.
// - Capability register reports the supported domain tag width.
// - Unsupported upper domain tag bits are reserved and dropped.
// - Table mode 00b makes root entries legacy single-pointer entries.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
module srd_ctx_decode (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic [7:0] paddr,
   input logic pwrite,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output srd_pkg::srd_mem_req_t mem_req,
   input logic [127:0] mem_rdata,
   input logic mem_ack
);
   // APB slave state
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] root_lo_reg, root_lo_next;
   logic [31:0] root_hi_reg, root_hi_next;
   logic [31:0] lookup_reg, lookup_next;
   logic wr_en, setup;

   // Walk state
   srd_pkg::srd_state_t state_reg, state_next;
   srd_pkg::srd_mem_req_t mreq_reg, mreq_next;
   logic [1:0] mode_reg, mode_next;
   logic [63:0] ctx_reg, ctx_next;
   logic [15:0] dom_reg, dom_next;
   logic [1:0] fault_reg, fault_next;
   logic done_reg, done_next;
   logic half_reg, half_next;

   // Decoder interface
   logic dec_load;
   srd_pkg::srd_ptr_t dec;
   logic dec_valid;

   // Derived fields
   logic [63:0] root_base;
   logic [7:0] bus_num;
   logic [7:0] devfn;
   logic [1:0] sw_mode;
   logic start;
   logic [31:0] status_word;

   assign root_base = {root_hi_reg, root_lo_reg[31:12], 12'h000};
   assign sw_mode = root_lo_reg[srd_pkg::MODE_LSB +: 2];
   assign bus_num = lookup_reg[srd_pkg::BUS_LSB +: 8];
   assign devfn = lookup_reg[srd_pkg::DEVFN_LSB +: 8];
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready_reg && pwrite;
   assign start = wr_en && paddr == srd_pkg::OFS_LOOKUP
                  && pwdata[srd_pkg::START_BIT] && state_reg == srd_pkg::S_IDLE;
   assign status_word = {26'h0, half_reg, fault_reg, (fault_reg != srd_pkg::FAULT_NONE),
                         done_reg, (state_reg != srd_pkg::S_IDLE)};

   // Register file; read data are prepared in the setup cycle
   always_comb begin
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      pready_next = setup;
      root_lo_next = root_lo_reg;
      root_hi_next = root_hi_reg;
      lookup_next = lookup_reg;
      if (setup) begin
         pslverr_next = 1'b0;
         unique case (paddr)
            srd_pkg::OFS_ROOT_LO: prdata_next = root_lo_reg;
            srd_pkg::OFS_ROOT_HI: prdata_next = root_hi_reg;
            srd_pkg::OFS_CAP: prdata_next = srd_pkg::CAP_VALUE;
            srd_pkg::OFS_LOOKUP: prdata_next = {(state_reg != srd_pkg::S_IDLE),
                                                lookup_reg[30:0]};
            srd_pkg::OFS_STATUS: prdata_next = status_word;
            srd_pkg::OFS_CTX_LO: prdata_next = ctx_reg[31:0];
            srd_pkg::OFS_CTX_HI: prdata_next = ctx_reg[63:32];
            srd_pkg::OFS_DOMAIN: prdata_next = {16'h0000, dom_reg};
            default: begin
               prdata_next = 32'h0000_0000;
               pslverr_next = 1'b1;
            end
         endcase
      end
      if (wr_en) begin
         unique case (paddr)
            srd_pkg::OFS_ROOT_LO: root_lo_next = {pwdata[31:12], 12'h000}
                                   | {20'h0, pwdata[11:10], 10'h0};
            srd_pkg::OFS_ROOT_HI: root_hi_next = pwdata;
            srd_pkg::OFS_LOOKUP: begin
               // A lookup in flight keeps its request fields
               if (state_reg == srd_pkg::S_IDLE) begin
                  lookup_next = {15'h0, pwdata[16:0]};
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         root_lo_reg <= srd_pkg::ROOT_LO_RST;
         root_hi_reg <= srd_pkg::ROOT_HI_RST;
         lookup_reg <= srd_pkg::LOOKUP_RST;
      end else begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         root_lo_reg <= root_lo_next;
         root_hi_reg <= root_hi_next;
         lookup_reg <= lookup_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   assign dec_load = state_reg == srd_pkg::S_ROOT && mem_ack;

   srd_root_decode u_dec (
      .clk(pclk),
      .rst_n(presetn),
      .load(dec_load),
      .entry(mem_rdata),
      .mode(mode_reg),
      .upper_sel(half_reg),
      .dec(dec),
      .dec_valid(dec_valid)
   );

   // Walk: root fetch, decode, context fetch
   always_comb begin
      state_next = state_reg;
      mreq_next = mreq_reg;
      mode_next = mode_reg;
      ctx_next = ctx_reg;
      dom_next = dom_reg;
      fault_next = fault_reg;
      done_next = done_reg;
      half_next = half_reg;
      unique case (state_reg)
         srd_pkg::S_IDLE: begin
            if (start) begin
               done_next = 1'b0;
               fault_next = srd_pkg::FAULT_NONE;
               mode_next = sw_mode;
               half_next = (sw_mode == srd_pkg::MODE_SCALABLE)
                           && pwdata[srd_pkg::DEVFN_LSB + srd_pkg::SM_HALF_BIT];
               if (pwdata[srd_pkg::PID_BIT]) begin
                  // Requests with a space id are not walked here
                  fault_next = srd_pkg::FAULT_PID;
                  done_next = 1'b1;
               end else if (sw_mode != srd_pkg::MODE_SCALABLE
                            && sw_mode != srd_pkg::MODE_LEGACY) begin
                  fault_next = srd_pkg::FAULT_BAD_MODE;
                  done_next = 1'b1;
               end else begin
                  mreq_next.req = 1'b1;
                  mreq_next.addr = root_base + {52'h0, pwdata[7:0], 4'h0};
                  state_next = srd_pkg::S_ROOT;
               end
            end
         end
         srd_pkg::S_ROOT: begin
            if (mem_ack) begin
               mreq_next.req = 1'b0;
               state_next = srd_pkg::S_DEC;
            end
         end
         srd_pkg::S_DEC: begin
            if (dec_valid) begin
               if (!dec.present) begin
                  fault_next = srd_pkg::FAULT_NOT_PRESENT;
                  ctx_next = 64'h0;
                  done_next = 1'b1;
                  state_next = srd_pkg::S_IDLE;
               end else begin
                  ctx_next = dec.ptr;
                  mreq_next.req = 1'b1;
                  // Scalable halves hold 128 entries of 32 bytes, legacy 256 of 16
                  if (mode_reg == srd_pkg::MODE_SCALABLE) begin
                     mreq_next.addr = dec.ptr + {52'h0, devfn[6:0], 5'h00};
                  end else begin
                     mreq_next.addr = dec.ptr + {52'h0, devfn, 4'h0};
                  end
                  state_next = srd_pkg::S_CTX;
               end
            end
         end
         srd_pkg::S_CTX: begin
            if (mem_ack) begin
               mreq_next.req = 1'b0;
               // Unsupported high tag bits are dropped, not checked
               dom_next = {{(srd_pkg::DOM_TAG_WIDTH - srd_pkg::DOM_TAG_BITS){1'b0}},
                           mem_rdata[srd_pkg::DOM_TAG_LSB +: srd_pkg::DOM_TAG_BITS]};
               done_next = 1'b1;
               state_next = srd_pkg::S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= srd_pkg::S_IDLE;
         mreq_reg <= '0;
         mode_reg <= srd_pkg::MODE_LEGACY;
         ctx_reg <= 64'h0;
         dom_reg <= 16'h0000;
         fault_reg <= srd_pkg::FAULT_NONE;
         done_reg <= 1'b0;
         half_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         mreq_reg <= mreq_next;
         mode_reg <= mode_next;
         ctx_reg <= ctx_next;
         dom_reg <= dom_next;
         fault_reg <= fault_next;
         done_reg <= done_next;
         half_reg <= half_next;
      end
   end

   assign mem_req = mreq_reg;

   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence root_issued_s;
      state_reg == srd_pkg::S_ROOT && mem_req.req;
   endsequence
   sequence ctx_issued_s;
      state_reg == srd_pkg::S_CTX && mem_req.req;
   endsequence

   root_index_a: assert property (
      start && !pwdata[16] && sw_mode == srd_pkg::MODE_SCALABLE
      |=> root_issued_s and (mem_req.addr == root_base + {52'h0, bus_num, 4'h0}))
      else $error("root entry address wrong");
   sm_ctx_addr_a: assert property (
      state_reg == srd_pkg::S_DEC && dec_valid && dec.present
      && mode_reg == srd_pkg::MODE_SCALABLE
      |=> ctx_issued_s and (mem_req.addr == ctx_reg + {52'h0, devfn[6:0], 5'h00}))
      else $error("scalable context address wrong");
   legacy_ctx_a: assert property (
      state_reg == srd_pkg::S_DEC && dec_valid && dec.present
      && mode_reg == srd_pkg::MODE_LEGACY
      |=> ctx_issued_s and (mem_req.addr == ctx_reg + {52'h0, devfn, 4'h0}))
      else $error("legacy context address wrong");
   half_pick_a: assert property (
      start && sw_mode == srd_pkg::MODE_SCALABLE
      |=> half_reg == $past(pwdata[15]))
      else $error("half select wrong");
   pid_refuse_a: assert property (
      start && pwdata[16]
      |=> state_reg == srd_pkg::S_IDLE && fault_reg == srd_pkg::FAULT_PID
          && done_reg && !mem_req.req)
      else $error("space id request walked");
   absent_half_a: assert property (
      state_reg == srd_pkg::S_DEC && dec_valid && !dec.present
      |=> fault_reg == srd_pkg::FAULT_NOT_PRESENT && !mem_req.req
          ##1 state_reg == srd_pkg::S_IDLE [*2])
      else $error("absent half not faulted");
   dom_tag_a: assert property (
      state_reg == srd_pkg::S_CTX && mem_ack
      |=> dom_reg == {8'h00, $past(mem_rdata[79:72])} && done_reg)
      else $error("domain tag wrong");
   cap_read_a: assert property (
      setup && paddr == srd_pkg::OFS_CAP
      |=> pready && prdata == srd_pkg::CAP_VALUE && !pslverr)
      else $error("capability read wrong");
   busy_hold_a: assert property (
      wr_en && paddr == srd_pkg::OFS_LOOKUP && state_reg != srd_pkg::S_IDLE
      |=> lookup_reg == $past(lookup_reg))
      else $error("lookup changed while busy");
   bad_mode_a: assert property (
      start && !pwdata[srd_pkg::PID_BIT] && sw_mode[1]
      |=> state_reg == srd_pkg::S_IDLE && fault_reg == srd_pkg::FAULT_BAD_MODE
          && done_reg && !mem_req.req)
      else $error("bad table mode walked");
endmodule // srd_ctx_decode

// [hdl/srd_pkg.sv]
// Constants, types and register map for the root/context entry decoder
package srd_pkg;
   localparam int HOST_ADDR_WIDTH = 48;
   localparam int DOM_TAG_BITS = 8;
   localparam int DOM_TAG_WIDTH = 16;
   localparam logic [63:0] HAW_MASK = (64'h1 << HOST_ADDR_WIDTH) - 64'h1;
   localparam logic [1:0] MODE_LEGACY = 2'h0;
   localparam logic [1:0] MODE_SCALABLE = 2'h1;
   localparam int UPPER_VALID_BIT = 64;
   localparam int UPPER_BASE_LSB = 76;
   localparam int LOWER_VALID_BIT = 0;
   localparam int LOWER_BASE_LSB = 12;
   localparam int DOM_TAG_LSB = 72;
   localparam int SM_HALF_BIT = 7;
   // Register byte offsets
   localparam logic [7:0] OFS_ROOT_LO = 8'h00;
   localparam logic [7:0] OFS_ROOT_HI = 8'h04;
   localparam logic [7:0] OFS_CAP = 8'h08;
   localparam logic [7:0] OFS_LOOKUP = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CTX_LO = 8'h14;
   localparam logic [7:0] OFS_CTX_HI = 8'h18;
   localparam logic [7:0] OFS_DOMAIN = 8'h1c;
   // Field positions
   localparam int MODE_LSB = 10;
   localparam int BUS_LSB = 0;
   localparam int DEVFN_LSB = 8;
   localparam int PID_BIT = 16;
   localparam int START_BIT = 31;
   localparam logic [31:0] ROOT_LO_RST = 32'h0000_0000;
   localparam logic [31:0] ROOT_HI_RST = 32'h0000_0000;
   localparam logic [31:0] LOOKUP_RST = 32'h0000_0000;
   localparam logic [31:0] CAP_VALUE = {16'h0000, 8'(HOST_ADDR_WIDTH), 8'(DOM_TAG_BITS)};
   // Fault codes
   localparam logic [1:0] FAULT_NONE = 2'h0;
   localparam logic [1:0] FAULT_NOT_PRESENT = 2'h1;
   localparam logic [1:0] FAULT_BAD_MODE = 2'h2;
   localparam logic [1:0] FAULT_PID = 2'h3;
   typedef struct packed {
      logic req;
      logic [63:0] addr;
   } srd_mem_req_t;
   typedef struct packed {
      logic present;
      logic [63:0] ptr;
   } srd_ptr_t;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_ROOT = 2'b01,
      S_DEC = 2'b10,
      S_CTX = 2'b11
   } srd_state_t;
endpackage

// [hdl/srd_root_decode.sv]
// Registered decoder of one root entry into a context table pointer
`timescale 1ns/10ps
module srd_root_decode (
   input logic clk,
   input logic rst_n,
   input logic load,
   input logic [127:0] entry,
   input logic [1:0] mode,
   input logic upper_sel,
   output srd_pkg::srd_ptr_t dec,
   output logic dec_valid
);
   srd_pkg::srd_ptr_t dec_reg, dec_next;
   logic valid_reg, valid_next;
   logic sm_upper;

   always_comb begin
      sm_upper = (mode == srd_pkg::MODE_SCALABLE) && upper_sel;
      dec_next = dec_reg;
      valid_next = load;
      if (load) begin
         if (sm_upper) begin
            dec_next.present = entry[srd_pkg::UPPER_VALID_BIT];
            dec_next.ptr = {entry[127:srd_pkg::UPPER_BASE_LSB], 12'h000}
                           & srd_pkg::HAW_MASK;
         end else begin
            // Legacy and scalable lower half share the same layout
            dec_next.present = entry[srd_pkg::LOWER_VALID_BIT];
            dec_next.ptr = {entry[63:srd_pkg::LOWER_BASE_LSB], 12'h000}
                           & srd_pkg::HAW_MASK;
         end
         // Not present: the rest of the half is ignored
         if (!dec_next.present) begin
            dec_next.ptr = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dec_reg <= '0;
         valid_reg <= 1'b0;
      end else begin
         dec_reg <= dec_next;
         valid_reg <= valid_next;
      end
   end

   assign dec = dec_reg;
   assign dec_valid = valid_reg;

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);

   upper_base_a: assert property (
      dec_valid && $past(mode) == srd_pkg::MODE_SCALABLE && $past(upper_sel) && dec.present
      |-> dec.ptr == ({$past(entry[127:76]), 12'h000} & srd_pkg::HAW_MASK))
      else $error("upper table base wrong");
   upper_valid_a: assert property (
      dec_valid && $past(mode) == srd_pkg::MODE_SCALABLE && $past(upper_sel)
      |-> dec.present == $past(entry[64]) && (dec.present || dec.ptr == '0))
      else $error("upper valid bit misread");
   lower_half_a: assert property (
      dec_valid && !($past(mode) == srd_pkg::MODE_SCALABLE && $past(upper_sel))
      |-> dec.present == $past(entry[0])
          && dec.ptr == (dec.present ? ({$past(entry[63:12]), 12'h000}
                                        & srd_pkg::HAW_MASK) : 64'h0))
      else $error("lower half misread");
   width_mask_a: assert property (
      dec.ptr[63:srd_pkg::HOST_ADDR_WIDTH] == '0 && dec.ptr[11:0] == 12'h000)
      else $error("pointer bits above width");
endmodule // srd_root_decode

// [testbench/srd_mem_model.sv]
// Behavioural system memory holding the software-built translation tables
`timescale 1ns/10ps
module srd_mem_model (
   input logic pclk,
   input logic presetn,
   input srd_pkg::srd_mem_req_t mem_req,
   output logic [127:0] mem_rdata,
   output logic mem_ack
);
   logic [127:0] mem [logic [63:0]];
   logic [63:0] addr_log [$];
   int unsigned max_wait = 4;
   int unsigned wait_cnt;
   int unsigned target;
   logic wait_low;

   function automatic void put(input logic [63:0] a, input logic [127:0] d);
      mem[a] = d;
   endfunction

   // Data is only meaningful with the acknowledge; it churns otherwise, except that it holds while a request waits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         mem_rdata <= 128'h0;
         wait_cnt <= 0;
         wait_low <= 1'b0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wait_low <= 1'b1;
      end else if (wait_low) begin
         // Old request may linger a cycle after the acknowledge
         mem_rdata <= ~mem_rdata;
         if (!mem_req.req) wait_low <= 1'b0;
      end else if (mem_req.req) begin
         if (wait_cnt == 0) begin
            target = $urandom_range(max_wait, 0);
            addr_log.push_back(mem_req.addr);
         end
         if (wait_cnt >= target) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem.exists(mem_req.addr) ? mem[mem_req.addr] :
                  {$urandom, $urandom, $urandom, $urandom};
            wait_cnt <= 0;
         end else begin
            wait_cnt <= wait_cnt + 1;
         end
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule // srd_mem_model

// [testbench/testbench.sv]
// Self-checking bench for the root and context entry walker
`timescale 1ns/10ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [127:0] mem_rdata;
   srd_pkg::srd_mem_req_t mem_req;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;

   srd_ctx_decode i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
         .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
         .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   srd_mem_model i_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
         .mem_rdata(mem_rdata), .mem_ack(mem_ack));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk64(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Idle cycle after each transfer keeps strobes from being reassigned in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge pclk);
         n++;
      end
      if (n == 16) num_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   function automatic logic [64:0] exp_ptr(input logic [1:0] mode, input logic [7:0] devfn,
         input logic [127:0] re);
      logic up;
      logic [63:0] p;
      up = (mode == srd_pkg::MODE_SCALABLE) && devfn[7];
      p = up ? {re[127:76], 12'h000} : {re[63:12], 12'h000};
      return {up ? re[64] : re[0], p & srd_pkg::HAW_MASK};
   endfunction

   task automatic run_one(input logic [1:0] mode, input logic pid, input logic poke);
      logic [63:0] base, raddr, caddr, e64;
      logic [64:0] ep;
      logic [127:0] re, ce;
      logic [7:0] bus, devfn;
      logic [31:0] d, st;
      logic [2:0] fc;
      logic err, up;
      int n;
      base = {16'h0000, 4'($urandom), 32'($urandom), 12'h000};
      bus = 8'($urandom);
      devfn = 8'($urandom);
      re = {$urandom, $urandom, $urandom, $urandom};
      re[75:65] = 11'h000;
      re[11:1] = 11'h000;
      re[0] = poke || ($urandom_range(3, 0) != 0);
      re[64] = poke || ($urandom_range(3, 0) != 0);
      if (mode == srd_pkg::MODE_LEGACY) re[127:64] = 64'h0;
      ce = {40'h0, 24'($urandom), $urandom, $urandom};
      raddr = base + {52'h0, bus, 4'h0};
      ep = exp_ptr(mode, devfn, re);
      up = (mode == srd_pkg::MODE_SCALABLE) && devfn[7];
      caddr = ep[63:0] + ((mode == srd_pkg::MODE_SCALABLE) ? {52'h0, devfn[6:0], 5'h00}
            : {52'h0, devfn, 4'h0});
      fc = pid ? 3'h7 : mode[1] ? 3'h5 : !ep[64] ? 3'h3 : 3'h0;
      i_mem.put(raddr, re);
      i_mem.put(caddr, ce);
      i_mem.addr_log.delete();
      apb(1'b1, srd_pkg::OFS_ROOT_HI, base[63:32], d, err);
      apb(1'b1, srd_pkg::OFS_ROOT_LO, {base[31:12], mode, 10'h000}, d, err);
      apb(1'b0, srd_pkg::OFS_ROOT_LO, 32'h0, d, err);
      chk32("root_lo", {base[31:12], mode, 10'h000}, d);
      apb(1'b1, srd_pkg::OFS_LOOKUP, {1'b1, 14'h0, pid, devfn, bus}, d, err);
      // A start while busy must leave the running walk alone
      if (poke) apb(1'b1, srd_pkg::OFS_LOOKUP, {1'b1, 15'h0, ~devfn, ~bus}, d, err);
      n = 0;
      st = 32'h1;
      while (st[0] !== 1'b0 && n < 40) begin
         apb(1'b0, srd_pkg::OFS_STATUS, 32'h0, st, err);
         n++;
      end
      if (n == 40) num_errors++;
      chk32("fault", 32'(fc), 32'(st[4:2]));
      apb(1'b0, srd_pkg::OFS_LOOKUP, 32'h0, d, err);
      chk32("lookup", {1'b0, 14'h0, pid, devfn, bus}, d);
      chk32("lookup_err", 32'h0, {31'h0, err});
      if (fc == 3'h0) begin
         chk32("status", {26'h0, up, 5'h02}, st);
         apb(1'b0, srd_pkg::OFS_DOMAIN, 32'h0, d, err);
         chk32("domain", {24'h0, ce[79:72]}, d);
         chk64("ctx_addr", caddr, i_mem.addr_log[1]);
      end
      if (fc == 3'h0 || fc == 3'h3) begin
         e64 = (fc == 3'h0) ? ep[63:0] : 64'h0;
         apb(1'b0, srd_pkg::OFS_CTX_LO, 32'h0, d, err);
         chk32("ctx_lo", e64[31:0], d);
         apb(1'b0, srd_pkg::OFS_CTX_HI, 32'h0, d, err);
         chk32("ctx_hi", e64[63:32], d);
         chk64("root_addr", raddr, i_mem.addr_log[0]);
      end
      chk32("fetches", (fc == 3'h0) ? 32'd2 : (fc == 3'h3) ? 32'd1 : 32'd0,
            32'(i_mem.addr_log.size()));
   endtask

   // Walks take tens of cycles; the ceiling leaves a wide margin
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   initial begin
      logic [31:0] d;
      logic err;
      void'($urandom(32'h6ede));
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, srd_pkg::OFS_CAP, 32'h0, d, err);
      chk32("cap", srd_pkg::CAP_VALUE, d);
      apb(1'b1, srd_pkg::OFS_CAP, 32'hffff_ffff, d, err);
      apb(1'b0, srd_pkg::OFS_CAP, 32'h0, d, err);
      chk32("cap_ro", srd_pkg::CAP_VALUE, d);
      apb(1'b0, srd_pkg::OFS_ROOT_LO, 32'h0, d, err);
      chk32("root_lo_rst", srd_pkg::ROOT_LO_RST, d);
      apb(1'b0, 8'h20, 32'h0, d, err);
      chk32("unmapped_err", 32'h1, {31'h0, err});
      chk32("unmapped_data", 32'h0, d);
      for (int i = 0; i < 28; i++) begin
         run_one(i < 4 ? 2'(i) : i < 6 ? srd_pkg::MODE_SCALABLE :
               ($urandom_range(5, 0) == 0 ? 2'h2 : 2'($urandom_range(1, 0))), i == 4, i == 5);
      end
      tally_and_finish();
   end
endmodule // testbench
